// ==== include/cbu_pkg.sv ====
// Constants, types and helpers shared by the chain battery UART framer
// What the document requires
// (R1) Twelve-bit character: start, data LSB first, parity, stops
// (R2) Message is preamble, data characters, then stop
// (R3) Each data byte goes as two nibble characters
// (R4) Encoded bit sent true, then complemented
// (R5) Preamble inserted automatically by default
// (R6) Stop character appended automatically by default
// (R7) Line rate selectable: 0.5, 1 or 2 Mbps
// (R8) No-preamble setting omits the leading preamble
// (R9) No-stop setting omits the trailing stop character
// (R10) Raw transmit setting sends bytes unencoded
// (R11) Raw receive setting passes bytes undecoded
// (R12) Preamble is unencoded 15h
// (R13) Preamble match ignores stop bits, else data
// (R14) Stop character is unencoded 54h
// (R15) Even parity; encoded data parity always zero; the odd_par setting gives odd parity instead (transmit only; the receiver always checks even parity)
// (R16) Host builds content and its CRC byte
// (R17) Keep-alive sends periodic stop characters when enabled
// (R18) Host pads reads with C2h or D3h fillers
// (R19) Host uses command bytes 57h, 02h, 03h
// (R20) Host assigns contiguous addresses 0 to 31
// (R21) Keep-alive gap 4-bit code, up to 10.24 ms
// (R22) Receiver delivers only data bytes inside frames
package cbu_pkg;
   // ****************************************
   // Clock and line timing
   // ****************************************
   localparam int CLK_HZ = 25000000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int BASE_BIT_HZ = 500000;
   localparam int BAUD_DIV = CLK_HZ / BASE_BIT_HZ;
   localparam int CHAR_BITS = 12;
   localparam logic [3:0] CHAR_LAST = 4'(CHAR_BITS - 1);
   localparam int KA_UNIT_NS = 10000;
   localparam int KA_UNIT_CYC = (KA_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int KA_MAX_NS = 10240000;
   localparam int KA_MAX_UNITS = KA_MAX_NS / KA_UNIT_NS;
   localparam logic [3:0] KA_CODE_MAX = 4'hC;
   // ****************************************
   // Framing codes
   // ****************************************
   localparam logic [7:0] PREAMBLE_CODE = 8'h15;
   localparam logic [7:0] STOP_CODE = 8'h54;
   // ****************************************
   // Register map
   // ****************************************
   localparam int REG_AW = 5;
   localparam logic [REG_AW-1:0] ADDR_CTRL = 5'h00;
   localparam logic [REG_AW-1:0] ADDR_STAT = 5'h04;
   localparam logic [REG_AW-1:0] ADDR_TXD = 5'h08;
   localparam logic [REG_AW-1:0] ADDR_RXD = 5'h0C;
   localparam int CTRL_W = 12;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
   localparam int TXD_LAST = 8;
   localparam int ST_TX_FULL = 0;
   localparam int ST_TX_BUSY = 1;
   localparam int ST_RX_VLD = 2;
   localparam int ST_OVR = 3;
   localparam int ST_PAR_ERR = 4;
   localparam int ST_MAN_ERR = 5;
   localparam int ST_STOP_ERR = 6;
   localparam int ST_IN_FRAME = 7;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      RATE_0M5 = 2'b00,
      RATE_1M = 2'b01,
      RATE_2M = 2'b10
   } cbu_rate_e;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_DATA = 2'b01,
      TX_HI = 2'b10,
      TX_END = 2'b11
   } cbu_txst_e;
   typedef struct packed {
      logic [3:0] ka;
      logic pause;
      logic odd_par;
      logic raw_rx;
      logic raw_tx;
      logic no_stop;
      logic no_pre;
      cbu_rate_e rate;
   } cbu_ctrl_s;
   typedef struct packed {
      logic vld;
      logic [7:0] data;
      logic par;
      logic stop_ok;
   } cbu_rxch_s;
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [11:0] mk_char(input logic [7:0] d, input logic odd);
      return {2'b11, ^d ^ odd, d, 1'b0}; // [R1] [R15]
   endfunction
   function automatic logic [7:0] man_enc(input logic [3:0] nib);
      logic [7:0] e;
      for (int i = 0; i < 4; i++) begin
         e[2*i] = nib[i]; // [R4]
         e[2*i+1] = ~nib[i];
      end
      return e;
   endfunction
   function automatic logic man_ok(input logic [7:0] d);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         ok = ok & (d[2*i+1] == ~d[2*i]);
      end
      return ok;
   endfunction
   function automatic logic [3:0] man_dec(input logic [7:0] d);
      return {d[6], d[4], d[2], d[0]};
   endfunction
   function automatic logic [2:0] rate_step(input cbu_rate_e r);
      case (r)
         RATE_1M: return 3'h2;
         RATE_2M: return 3'h4;
         default: return 3'h1;
      endcase
   endfunction
   function automatic logic [10:0] ka_gap_units(input logic [3:0] ka);
      if (ka <= 4'h1) begin
         return 11'h000;
      end else if (ka >= KA_CODE_MAX) begin
         return 11'(KA_MAX_UNITS);
      end else begin
         return 11'h001 << (ka - 4'h2);
      end
   endfunction
endpackage

// ==== rtl/cbu_baud.sv ====
// Bit-time tick generator with a fractional phase step
`timescale 1ns/1ps
module cbu_baud #(
   parameter int DIV = cbu_pkg::BAUD_DIV,
   parameter int PRELOAD = 0
) (
   input logic hclk, // Clock
   input logic hresetn, // Asynchronous reset, active low
   input logic restart, // Restart the bit timer
   input logic [2:0] step, // Phase step per clock
   output logic tick // One pulse per bit time
);
   import cbu_pkg::*;
   localparam int AW = $clog2(DIV) + 1;
   localparam logic [AW-1:0] DIV_W = AW'(DIV);
   localparam logic [AW-1:0] PRE_W = AW'(PRELOAD);
   typedef struct packed {
      logic [AW-1:0] acc;
   } cbu_baud_s;
   cbu_baud_s q;
   cbu_baud_s next_q;
   logic [AW-1:0] sum;

   always_comb begin
      sum = q.acc + AW'(step);
      next_q = q;
      tick = 1'b0;
      if (restart) begin
         next_q.acc = PRE_W;
      end else if (sum >= DIV_W) begin
         next_q.acc = sum - DIV_W;
         tick = 1'b1; // [R7]
      end else begin
         next_q.acc = sum;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// ==== rtl/cbu_rx_char.sv ====
// Receiver for one 12-bit line character
`timescale 1ns/1ps
module cbu_rx_char (
   input logic hclk, // Clock
   input logic hresetn, // Asynchronous reset, active low
   input logic rx_line, // Serial line in, idle high
   input logic tick, // Mid-bit sampling tick
   output logic restart, // Start edge seen, realign tick
   output cbu_pkg::cbu_rxch_s ch // Received character
);
   import cbu_pkg::*;
   typedef struct packed {
      logic busy;
      logic [3:0] cnt;
      logic [11:0] sh;
      cbu_rxch_s ch;
   } cbu_rxc_s;
   cbu_rxc_s q;
   cbu_rxc_s next_q;
   logic [11:0] full;

   always_comb begin
      full = {rx_line, q.sh[11:1]};
      next_q = q;
      next_q.ch.vld = 1'b0;
      restart = !q.busy && !rx_line;
      if (restart) begin
         next_q.busy = 1'b1;
         next_q.cnt = 4'h0;
      end else if (q.busy && tick) begin
         if (q.cnt == 4'h0 && rx_line) begin
            // Glitch, not a start bit
            next_q.busy = 1'b0;
         end else begin
            next_q.sh = full;
            next_q.cnt = q.cnt + 4'h1;
            if (q.cnt == CHAR_LAST) begin
               next_q.busy = 1'b0;
               next_q.ch.vld = 1'b1; // [R1]
               next_q.ch.data = full[8:1];
               next_q.ch.par = full[9];
               next_q.ch.stop_ok = &full[11:10];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign ch = q.ch;
endmodule

// ==== rtl/cbu_framer.sv ====
// Chain battery UART framer: register slave, transmit framing, receive deframing
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module cbu_framer #(
   parameter int KA_UNIT = cbu_pkg::KA_UNIT_CYC
) (
   input logic hclk, // Clock, 25 MHz
   input logic hresetn, // Asynchronous reset, active low
   input logic hsel, // Slave select
   input logic [31:0] haddr, // Byte address
   input logic [1:0] htrans, // Transfer type
   input logic hwrite, // Write when high
   input logic [2:0] hsize, // Transfer size, words only
   input logic [31:0] hwdata, // Write data
   input logic hready, // Bus ready in
   output logic hreadyout, // Slave ready out
   output logic [31:0] hrdata, // Read data
   output logic hresp, // Response, always OKAY
   output logic tx_line, // Serial line out, idle high
   input logic rx_line // Serial line in, idle high
);
   import cbu_pkg::*;

   // ****************************************
   // State
   // ****************************************
   localparam int KCW = $clog2(KA_UNIT + 1);
   localparam logic [KCW-1:0] KA_CYC_LAST = KCW'(KA_UNIT - 1);

   typedef struct packed {
      logic hready_o;
      logic hresp_o;
      logic [31:0] rdata;
      logic dp_wr;
      logic [REG_AW-1:0] dp_addr;
      cbu_ctrl_s ctrl;
      logic txq_vld;
      logic [7:0] txq;
      logic txq_last;
      cbu_txst_e st;
      logic [7:0] cur;
      logic cur_last;
      logic tx_line;
      logic sh_busy;
      logic [10:0] sh;
      logic [3:0] sh_cnt;
      logic [KCW-1:0] ka_cyc;
      logic [10:0] ka_units;
      logic rx_vld;
      logic [7:0] rx_byte;
      logic in_frame;
      logic half;
      logic [3:0] lo_nib;
      logic ovr;
      logic par_err;
      logic man_err;
      logic stop_err;
   } cbu_top_s;

   cbu_top_s q;
   cbu_top_s n;

   logic tx_tick;
   logic rx_tick;
   logic rx_restart;
   logic [2:0] step;
   cbu_rxch_s rxch;

   logic acc;
   logic ld;
   logic [11:0] ld_char;
   logic idle_now;
   logic ka_fire;
   logic [10:0] ka_target;
   logic is_pre;
   logic is_stop;
   logic deliver;
   logic [7:0] dbyte;
   logic [31:0] stat;
   logic [31:0] clr;

   assign step = rate_step(q.ctrl.rate);

   // ****************************************
   // Bit timing and character receiver
   // ****************************************
   cbu_baud #(
      .DIV(BAUD_DIV),
      .PRELOAD(0)
   ) u_tx_baud (
      .hclk(hclk),
      .hresetn(hresetn),
      .restart(ld),
      .step(step),
      .tick(tx_tick)
   );

   cbu_baud #(
      .DIV(BAUD_DIV),
      .PRELOAD(BAUD_DIV / 2)
   ) u_rx_baud (
      .hclk(hclk),
      .hresetn(hresetn),
      .restart(rx_restart),
      .step(step),
      .tick(rx_tick)
   );

   cbu_rx_char u_rx_char (
      .hclk(hclk),
      .hresetn(hresetn),
      .rx_line(rx_line),
      .tick(rx_tick),
      .restart(rx_restart),
      .ch(rxch)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      n = q;
      ld = 1'b0;
      ld_char = 12'hFFF;
      deliver = 1'b0;
      dbyte = 8'h00;
      clr = 32'h0000_0000;
      n.hready_o = 1'b1;
      n.hresp_o = 1'b0;

      stat = 32'h0000_0000;
      stat[ST_TX_FULL] = q.txq_vld;
      stat[ST_TX_BUSY] = q.sh_busy || (q.st != TX_IDLE);
      stat[ST_RX_VLD] = q.rx_vld;
      stat[ST_OVR] = q.ovr;
      stat[ST_PAR_ERR] = q.par_err;
      stat[ST_MAN_ERR] = q.man_err;
      stat[ST_STOP_ERR] = q.stop_err;
      stat[ST_IN_FRAME] = q.in_frame;

      // Data phase of a write
      if (q.dp_wr) begin
         case (q.dp_addr)
            ADDR_CTRL: begin
               n.ctrl = cbu_ctrl_s'(hwdata[CTRL_W-1:0]);
            end
            ADDR_STAT: begin
               clr = hwdata;
            end
            ADDR_TXD: begin
               // Ignored while the holding register is full
               if (!q.txq_vld) begin
                  n.txq_vld = 1'b1;
                  n.txq = hwdata[7:0];
                  n.txq_last = hwdata[TXD_LAST];
               end
            end
            default: begin
            end
         endcase
      end

      // Address phase
      acc = hsel && hready && htrans[1];
      n.dp_wr = acc && hwrite;
      n.dp_addr = haddr[REG_AW-1:0];
      if (acc && !hwrite) begin
         case (haddr[REG_AW-1:0])
            ADDR_CTRL: n.rdata = {{(32 - CTRL_W){1'b0}}, q.ctrl};
            ADDR_STAT: n.rdata = stat;
            ADDR_RXD: begin
               n.rdata = {24'h000000, q.rx_byte};
               n.rx_vld = 1'b0;
            end
            default: n.rdata = 32'h0000_0000;
         endcase
      end

      // Sticky error clears; later sets override
      n.ovr = q.ovr & ~clr[ST_OVR];
      n.par_err = q.par_err & ~clr[ST_PAR_ERR];
      n.man_err = q.man_err & ~clr[ST_MAN_ERR];
      n.stop_err = q.stop_err & ~clr[ST_STOP_ERR];

      // Keep-alive timing
      ka_target = ka_gap_units(q.ctrl.ka); // [R21]
      idle_now = (q.st == TX_IDLE) && !q.sh_busy && !q.txq_vld
         && (q.ctrl.ka != 4'h0) && !q.ctrl.pause;
      ka_fire = idle_now && (q.ka_units >= ka_target); // [R17]

      // Character shifter and message sequencer
      if (q.sh_busy) begin
         if (tx_tick) begin
            if (q.sh_cnt == 4'h0) begin
               n.sh_busy = 1'b0;
            end else begin
               n.tx_line = q.sh[0]; // [R1]
               n.sh = {1'b1, q.sh[10:1]};
               n.sh_cnt = q.sh_cnt - 4'h1;
            end
         end
      end else if (!q.ctrl.pause) begin
         case (q.st)
            TX_IDLE: begin
               if (q.txq_vld) begin
                  n.st = TX_DATA;
                  if (!q.ctrl.no_pre) begin // [R8]
                     ld = 1'b1;
                     ld_char = mk_char(PREAMBLE_CODE, q.ctrl.odd_par); // [R2] [R5] [R12]
                  end
               end else if (ka_fire) begin
                  ld = 1'b1;
                  ld_char = mk_char(STOP_CODE, q.ctrl.odd_par); // [R17] [R14]
               end
            end
            TX_DATA: begin
               if (q.txq_vld) begin
                  n.txq_vld = 1'b0;
                  n.cur = q.txq;
                  n.cur_last = q.txq_last;
                  ld = 1'b1;
                  if (q.ctrl.raw_tx) begin
                     ld_char = mk_char(q.txq, q.ctrl.odd_par); // [R10]
                     n.st = q.txq_last ? TX_END : TX_DATA;
                  end else begin
                     ld_char = mk_char(man_enc(q.txq[3:0]), q.ctrl.odd_par); // [R3] [R4]
                     n.st = TX_HI;
                  end
               end
            end
            TX_HI: begin
               ld = 1'b1;
               ld_char = mk_char(man_enc(q.cur[7:4]), q.ctrl.odd_par); // [R3] [R15]
               n.st = q.cur_last ? TX_END : TX_DATA;
            end
            TX_END: begin
               n.st = TX_IDLE;
               if (!q.ctrl.no_stop) begin // [R9]
                  ld = 1'b1;
                  ld_char = mk_char(STOP_CODE, q.ctrl.odd_par); // [R6] [R14]
               end
            end
            default: begin
               n.st = TX_IDLE;
            end
         endcase
      end

      if (ld) begin
         n.sh_busy = 1'b1;
         n.tx_line = ld_char[0];
         n.sh = ld_char[11:1];
         n.sh_cnt = CHAR_LAST;
      end

      // Gap counter runs only across true idle time
      if (!idle_now || ld) begin
         n.ka_cyc = '0;
         n.ka_units = 11'h000;
      end else if (!ka_fire) begin
         if (q.ka_cyc == KA_CYC_LAST) begin
            n.ka_cyc = '0;
            n.ka_units = q.ka_units + 11'h001;
         end else begin
            n.ka_cyc = q.ka_cyc + KCW'(1);
         end
      end

      // Receive deframing
      is_pre = (rxch.data == PREAMBLE_CODE) && (rxch.par == ^PREAMBLE_CODE); // [R13]
      is_stop = (rxch.data == STOP_CODE) && (rxch.par == ^STOP_CODE);
      if (rxch.vld) begin
         if (is_pre) begin
            n.in_frame = 1'b1; // [R22]
            n.half = 1'b0;
         end else if (is_stop) begin
            n.in_frame = 1'b0; // [R22]
            n.half = 1'b0;
         end else if (q.in_frame) begin
            if (rxch.par != ^rxch.data) begin
               n.par_err = 1'b1;
            end
            if (!rxch.stop_ok) begin
               n.stop_err = 1'b1;
            end
            if (q.ctrl.raw_rx) begin
               deliver = 1'b1; // [R11]
               dbyte = rxch.data;
            end else begin
               if (!man_ok(rxch.data)) begin
                  n.man_err = 1'b1;
               end
               if (!q.half) begin
                  n.lo_nib = man_dec(rxch.data); // [R3]
                  n.half = 1'b1;
               end else begin
                  deliver = 1'b1;
                  dbyte = {man_dec(rxch.data), q.lo_nib};
                  n.half = 1'b0;
               end
            end
         end
      end

      if (deliver) begin
         if (n.rx_vld) begin
            n.ovr = 1'b1;
         end
         n.rx_vld = 1'b1; // [R22]
         n.rx_byte = dbyte;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.hready_o <= 1'b1;
         q.tx_line <= 1'b1;
         q.ctrl <= cbu_ctrl_s'(CTRL_RESET);
         q.st <= TX_IDLE;
      end else begin
         q <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign hreadyout = q.hready_o;
   assign hresp = q.hresp_o;
   assign hrdata = q.rdata;
   assign tx_line = q.tx_line;
endmodule

// ==== sim/cbu_framer_properties.sv ====
// Concurrent checks on the framer's bus and line ports
`timescale 1ns/1ps
module cbu_framer_properties #(
   parameter int KA_UNIT = 250
) (
   input logic hclk, // Clock
   input logic hresetn, // Reset, active low
   input logic hsel, // Slave select
   input logic [31:0] haddr, // Byte address
   input logic [1:0] htrans, // Transfer type
   input logic hwrite, // Write when high
   input logic hready, // Bus ready in
   input logic hreadyout, // Slave ready out
   input logic [31:0] hrdata, // Read data
   input logic hresp, // Response
   input logic tx_line // Serial line out
);
   import cbu_pkg::*;
   // ****************************************
   // Helpers
   // ****************************************
   logic rd_ph;
   logic [9:0] lo_run;
   assign rd_ph = hsel && hready && htrans[1] && !hwrite;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lo_run <= 10'h000;
      end else begin
         lo_run <= tx_line ? 10'h000 : lo_run + 10'h001;
      end
   end
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ****************************************
   // Properties
   // ****************************************
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not OKAY");
   a_rdata_holds: assert property (!rd_ph |=> $stable(hrdata))
      else $error("hrdata changed without a read");
   a_txd_reads_zero: assert property (rd_ph && haddr[4:0] == ADDR_TXD |=> hrdata == 32'h0)
      else $error("TXD read not zero");
   a_unmapped_zero: assert property (rd_ph && haddr[4] |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_upper: assert property (rd_ph && haddr[4:0] == ADDR_STAT |=> hrdata[31:8] == 24'h0)
      else $error("status upper bits set");
   a_low_bit_min: assert property ($fell(tx_line) |-> (!tx_line) [*8])
      else $error("low bit too short");
   a_high_bit_min: assert property ($rose(tx_line) |-> tx_line [*8])
      else $error("high bit too short");
   a_low_run_max: assert property (lo_run <= 10'h1F4)
      else $error("line low beyond ten bit times");
endmodule
bind cbu_framer cbu_framer_properties #(.KA_UNIT(KA_UNIT)) cbu_framer_properties_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .tx_line(tx_line)
);

// ==== sim/cbu_chain_model.sv ====
// Daisy-chain model: returns the host's line after a fixed delay
`timescale 1ns/1ps
module cbu_chain_model #(
   parameter int DLY = 30
) (
   input logic hclk, // Clock
   input logic hresetn, // Reset, active low
   input logic tx_line, // Line from the framer
   output logic rx_line // Line back to the framer, idle high
);
   logic [DLY-1:0] pipe;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pipe <= '1;
      end else begin
         pipe <= {pipe[DLY-2:0], tx_line};
      end
   end
   assign rx_line = pipe[DLY-1];
endmodule

// ==== sim/cbu_framer_tb.sv ====
// Self-checking bench for the chain battery UART framer
`timescale 1ns/1ps
module cbu_framer_tb;
   import cbu_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic tx_line;
   logic rx_line;
   logic [31:0] q;
   logic [11:0] c;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   cbu_framer #(.KA_UNIT(4)) cbu_framer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .tx_line(tx_line), .rx_line(rx_line));
   cbu_chain_model #(.DLY(30)) cbu_chain_model_i (.hclk(hclk), .hresetn(hresetn),
      .tx_line(tx_line), .rx_line(rx_line));
   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   always #20 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {27'h0, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
      hsel <= 1'b0;
   endtask
   function automatic logic [11:0] ch(input logic [7:0] d);
      return {2'b11, ^d, d, 1'b0};
   endfunction
   function automatic logic [7:0] me(input logic [3:0] n);
      logic [7:0] e;
      for (int i = 0; i < 4; i++) begin
         e[2*i] = n[i];
         e[2*i+1] = ~n[i];
      end
      return e;
   endfunction
   // Samples one character at mid-bit, returns in the second stop bit
   task automatic grab(input int bns, output logic [11:0] r);
      @(negedge tx_line);
      #(bns / 2 + 10);
      for (int i = 0; i < 12; i++) begin
         r[i] = tx_line;
         if (i < 11) #(bns);
      end
   endtask
   task automatic rxpoll(output logic [31:0] s);
      s = 32'h0;
      for (int i = 0; i < 100 && s[ST_RX_VLD] !== 1'b1; i++) begin
         bus(1'b0, ADDR_STAT, 32'h0, s);
      end
   endtask
   task automatic xmit(input logic [11:0] ctl, input logic [31:0] m, input int n);
      logic [31:0] s;
      logic [11:0] exp [$];
      int bns;
      bns = (ctl[1:0] == 2'h1) ? 1000 : (ctl[1:0] == 2'h2) ? 500 : 2000;
      if (!ctl[2]) exp.push_back(ch(PREAMBLE_CODE));
      for (int i = 0; i < n; i++) begin
         if (ctl[4]) begin
            exp.push_back(ch(m[8*i+:8]));
         end else begin
            exp.push_back(ch(me(m[8*i+:4])));
            exp.push_back(ch(me(m[8*i+4+:4])));
         end
      end
      if (!ctl[3]) exp.push_back(ch(STOP_CODE));
      bus(1'b1, ADDR_CTRL, {20'h0, ctl}, s);
      bus(1'b0, ADDR_CTRL, 32'h0, s);
      chk(s, {20'h0, ctl});
      fork
         for (int i = 0; i < n; i++) begin
            s = 32'h1;
            while (s[ST_TX_FULL] !== 1'b0) bus(1'b0, ADDR_STAT, 32'h0, s);
            bus(1'b1, ADDR_TXD, {23'h0, i == n - 1, m[8*i+:8]}, s);
         end
         foreach (exp[k]) begin
            grab(bns, c);
            chk({20'h0, c}, {20'h0, exp[k]});
         end
      join
      // Let the echo of the last character clear the receiver before moving on
      repeat (80) @(posedge hclk);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, ADDR_CTRL, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b1, 5'h14, 32'hFFFF_FFFF, q);
      bus(1'b0, 5'h14, 32'h0, q);
      chk(q, 32'h0);
      xmit(12'h000, 32'h5DC21003, 4);
      rxpoll(q);
      bus(1'b0, ADDR_RXD, 32'h0, q);
      chk(q, 32'h5D);
      bus(1'b0, ADDR_STAT, 32'h0, q);
      chk({29'h0, q[ST_OVR], q[ST_RX_VLD], q[ST_IN_FRAME]}, 32'h4);
      xmit(12'h009, 32'h0557, 2);
      rxpoll(q);
      chk({31'h0, q[ST_IN_FRAME]}, 32'h1);
      bus(1'b0, ADDR_RXD, 32'h0, q);
      chk(q, 32'h05);
      xmit(12'h006, 32'h96, 1);
      rxpoll(q);
      bus(1'b0, ADDR_RXD, 32'h0, q);
      chk(q, 32'h96);
      xmit(12'h004, 32'h77, 1);
      rxpoll(q);
      chk({30'h0, q[ST_RX_VLD], q[ST_IN_FRAME]}, 32'h0);
      xmit(12'h032, 32'hA5, 1);
      rxpoll(q);
      bus(1'b0, ADDR_RXD, 32'h0, q);
      chk(q, 32'hA5);
      bus(1'b1, ADDR_CTRL, 32'h240, q);
      grab(2000, c);
      chk({20'h0, c}, {20'h0, ch(STOP_CODE) ^ 12'h200});
      bus(1'b1, ADDR_CTRL, 32'h0, q);
      results();
   end
endmodule
